// file: design/pbp_params.svh
// Constants for the parallel byte port: widths, depths and pin decode values.
`ifndef PBP_PARAMS_SVH
`define PBP_PARAMS_SVH
`define PBP_DATA_W 8
`define PBP_FIFO_DEPTH 32
`define PBP_FIFO_LVL_W 6
`define PBP_DIR_ALL_IN 3'h7
`define PBP_CFG_DIGITAL_MIN 4'hA
`define PBP_CFG_DIGITAL_MAX 4'hF
`define PBP_SYNC_STAGES 2
`endif

// file: design/pbp_pkg.sv
// Types shared by the parallel byte port modules.
package pbp_pkg;
    typedef enum logic [1:0] {
        PBP_IDLE = 2'b00,
        PBP_WRITE = 2'b01,
        PBP_READ = 2'b10
    } pbp_state_e;
    typedef logic [7:0] pbp_byte_t;
endpackage : pbp_pkg

// file: design/pbp_stream_if.sv
// Valid/ready byte stream between the port logic and its buffer.
`timescale 1ns/1ps
interface pbp_stream_if #(parameter int W = 8);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : pbp_stream_if

// file: design/pbp_fifo.sv
// Byte FIFO with a registered output stage, parameterised in width and depth.
`timescale 1ns/1ps
module pbp_fifo #(
    parameter int W = 8,
    parameter int D = 32,
    parameter int AW = 5
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    pbp_stream_if.snk in_if,
    pbp_stream_if.src out_if,
    output logic [AW:0] level_o
);
    logic [W-1:0] mem [D];
    logic [AW-1:0] wp_r;
    logic [AW-1:0] rp_r;
    logic [AW:0] cnt_r;
    logic out_valid_r;
    logic [W-1:0] out_data_r;
    logic push;
    logic load;
    logic [AW:0] lvl;

    // Full counts the output stage too, so the buffer never holds more than D words.
    assign lvl = cnt_r + {{AW{1'b0}}, out_valid_r};
    assign in_if.ready = (lvl != (AW+1)'(D)) ? 1'b1 : 1'b0;
    assign push = ce_i & in_if.valid & in_if.ready;
    // The output stage refills whenever it is empty or being taken this cycle.
    assign load = ce_i & (cnt_r != '0) & (~out_valid_r | out_if.ready);
    assign out_if.valid = out_valid_r;
    assign out_if.data = out_data_r;
    assign level_o = lvl;

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[wp_r] <= in_if.data;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
        end else begin
            if (push) begin
                wp_r <= wp_r + 1'b1;
            end
            if (load) begin
                rp_r <= rp_r + 1'b1;
            end
            cnt_r <= cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, load};
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            out_valid_r <= 1'b0;
            out_data_r <= '0;
        end else if (ce_i) begin
            if (load) begin
                out_valid_r <= 1'b1;
                out_data_r <= mem[rp_r];
            end else if (out_if.ready) begin
                out_valid_r <= 1'b0;
            end
        end
    end
endmodule : pbp_fifo

// file: design/pbp_port.sv
// Parallel slave byte port: host strobe decode, data latch, flags and assertions.
//
// Operation
// - Control-direction bit 4 set switches the data port into slave operation.
// - Slave operation stays off while the PWM unit runs two or four outputs.
// - Control pins 0, 1, 2 act as read, write and chip-select, active low.
// - Strobes act only while the three control direction bits are all input.
// - Strobes act only while analog port config lies between 1010 and 1111.
// - Host write spans chip-select and write low; ends when either goes high.
// - End of host write sets port event and input buffer full flags.
// - Host read start drives the latch onto data pins and clears output full.
// - Firmware latch write sets output full, except during a read: drive, keep clear.
// - Read end releases the data pins to input and sets the port event flag.
// - Host accesses may come at any time relative to the device clock.
// - Firmware waits for port event, then checks the buffer full flags.
`timescale 1ns/1ps
`include "pbp_params.svh"
module pbp_port (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic slave_mode_enable_i,
    input wire logic [2:0] control_port_direction_i,
    input wire logic [3:0] analog_port_config_i,
    input wire logic pwm_multi_output_i,
    input wire logic control_pin_0_i,
    input wire logic control_pin_1_i,
    input wire logic control_pin_2_i,
    input wire pbp_pkg::pbp_byte_t data_i,
    output pbp_pkg::pbp_byte_t data_o,
    output logic data_oe_n_o,
    input wire logic fw_wr_i,
    input wire pbp_pkg::pbp_byte_t fw_wdata_i,
    input wire logic fw_rd_i,
    output pbp_pkg::pbp_byte_t fw_rdata_o,
    output logic fw_rvalid_o,
    input wire logic port_event_clr_i,
    output logic port_event_flag_o,
    output logic input_buffer_full_o,
    output logic output_buffer_full_o,
    output logic overflow_o,
    output logic slave_active_o
);
    import pbp_pkg::*;

    pbp_state_e st_r;
    pbp_state_e st_nxt;
    logic [2:0] sync1_r;
    logic [2:0] sync2_r;
    pbp_byte_t data1_r;
    pbp_byte_t data2_r;
    logic mode_on;
    logic rd_n_s;
    logic wr_n_s;
    logic cs_n_s;
    logic wr_start;
    logic rd_start;
    logic wr_end;
    logic rd_end;
    pbp_byte_t latch_r;
    pbp_byte_t wbyte_r;
    logic oe_n_r;
    logic event_r;
    logic ibf_r;
    logic obf_r;
    logic ovf_r;
    logic pend_r;
    pbp_byte_t pend_data_r;
    logic mode_r;
    logic [5:0] level;
    logic pop;

    pbp_stream_if #(.W(`PBP_DATA_W)) in_s ();
    pbp_stream_if #(.W(`PBP_DATA_W)) out_s ();

    // True when the configuration lets the control pins act as digital strobes.
    function automatic logic strobes_usable(input logic en, input logic pwm_multi,
                                            input logic [2:0] dir, input logic [3:0] cfg);
        strobes_usable = en & ~pwm_multi & (dir == `PBP_DIR_ALL_IN)
                         & (cfg >= `PBP_CFG_DIGITAL_MIN) & (cfg <= `PBP_CFG_DIGITAL_MAX);
    endfunction : strobes_usable

    assign mode_on = strobes_usable(slave_mode_enable_i, pwm_multi_output_i,
                                    control_port_direction_i, analog_port_config_i);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync1_r <= 3'h7;
            sync2_r <= 3'h7;
        end else if (ce_i) begin
            sync1_r <= {control_pin_2_i, control_pin_1_i, control_pin_0_i};
            sync2_r <= sync1_r;
        end
    end

    // Data is delayed as far as the strobes so the byte seen at the end of a
    // write is the one the host held while its strobes were still low.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            data1_r <= 8'h00;
            data2_r <= 8'h00;
        end else if (ce_i) begin
            data1_r <= data_i;
            data2_r <= data1_r;
        end
    end

    assign rd_n_s = sync2_r[0];
    assign wr_n_s = sync2_r[1];
    assign cs_n_s = sync2_r[2];

    assign wr_start = (st_r == PBP_IDLE) & mode_on & ~cs_n_s & ~wr_n_s;
    assign rd_start = (st_r == PBP_IDLE) & mode_on & ~cs_n_s & ~rd_n_s & wr_n_s;
    assign wr_end = (st_r == PBP_WRITE) & (cs_n_s | wr_n_s | ~mode_on);
    assign rd_end = (st_r == PBP_READ) & (cs_n_s | rd_n_s | ~mode_on);

    always_comb begin
        st_nxt = st_r;
        unique case (st_r)
            PBP_IDLE: begin
                if (wr_start) begin
                    st_nxt = PBP_WRITE;
                end else if (rd_start) begin
                    st_nxt = PBP_READ;
                end
            end
            PBP_WRITE: begin
                if (wr_end) begin
                    st_nxt = PBP_IDLE;
                end
            end
            PBP_READ: begin
                if (rd_end) begin
                    st_nxt = PBP_IDLE;
                end
            end
            default: begin
                st_nxt = PBP_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_r <= PBP_IDLE;
        end else if (ce_i) begin
            st_r <= st_nxt;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mode_r <= 1'b0;
        end else if (ce_i) begin
            mode_r <= mode_on;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wbyte_r <= 8'h00;
        end else if (ce_i && (wr_start || (st_r == PBP_WRITE && !wr_end))) begin
            wbyte_r <= data2_r;
        end
    end

    // A finished write waits here when the buffer is full; a second write
    // ending before it drains is dropped and flagged, never overwrites.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pend_r <= 1'b0;
            pend_data_r <= 8'h00;
        end else if (ce_i) begin
            if (wr_end && (!pend_r || in_s.ready)) begin
                pend_r <= 1'b1;
                pend_data_r <= wbyte_r;
            end else if (in_s.ready) begin
                pend_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ovf_r <= 1'b0;
        end else if (ce_i) begin
            if (wr_end && pend_r && !in_s.ready) begin
                ovf_r <= 1'b1;
            end else if (port_event_clr_i) begin
                ovf_r <= 1'b0;
            end
        end
    end

    assign in_s.valid = pend_r;
    assign in_s.data = pend_data_r;
    assign out_s.ready = fw_rd_i;
    assign pop = ce_i & fw_rd_i & out_s.valid;

    pbp_fifo #(.W(`PBP_DATA_W), .D(`PBP_FIFO_DEPTH), .AW(5)) u_fifo (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .in_if(in_s),
        .out_if(out_s),
        .level_o(level)
    );

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            latch_r <= 8'h00;
        end else if (ce_i && fw_wr_i) begin
            latch_r <= fw_wdata_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            oe_n_r <= 1'b1;
        end else if (ce_i) begin
            oe_n_r <= ~((st_nxt == PBP_READ));
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            obf_r <= 1'b0;
        end else if (ce_i) begin
            if (rd_start || st_r == PBP_READ) begin
                obf_r <= 1'b0;
            end else if (fw_wr_i) begin
                obf_r <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ibf_r <= 1'b0;
        end else if (ce_i) begin
            if (wr_end) begin
                ibf_r <= 1'b1;
            end else if (pop && level == 6'h01 && !pend_r) begin
                ibf_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            event_r <= 1'b0;
        end else if (ce_i) begin
            if (wr_end || rd_end) begin
                event_r <= 1'b1;
            end else if (port_event_clr_i) begin
                event_r <= 1'b0;
            end
        end
    end

    assign data_o = latch_r;
    assign data_oe_n_o = oe_n_r;
    assign fw_rdata_o = out_s.data;
    assign fw_rvalid_o = out_s.valid;
    assign port_event_flag_o = event_r;
    assign input_buffer_full_o = ibf_r;
    assign output_buffer_full_o = obf_r;
    assign overflow_o = ovf_r;
    assign slave_active_o = mode_r;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    sequence write_ends_s;
        ce_i && st_r == PBP_WRITE && (cs_n_s || wr_n_s);
    endsequence
    sequence read_opens_s;
        ce_i && rd_start;
    endsequence
    sequence read_closes_s;
        ce_i && rd_end;
    endsequence

    mode_gate_a: assert property (
        ce_i && !mode_on |=> st_r == PBP_IDLE && data_oe_n_o
    ) else $error("port left idle while slave operation disabled");

    write_window_a: assert property (
        ce_i && st_r == PBP_IDLE && mode_on && !cs_n_s && !wr_n_s |=> st_r == PBP_WRITE
    ) else $error("write strobes low did not open a write");

    write_flags_a: assert property (
        write_ends_s |=> port_event_flag_o && input_buffer_full_o && st_r == PBP_IDLE
    ) else $error("write end did not raise event and input full");

    read_drive_a: assert property (
        read_opens_s |=> !data_oe_n_o && !output_buffer_full_o
    ) else $error("read start did not drive pins and clear output full");

    read_bypass_a: assert property (
        ce_i && st_r == PBP_READ && !rd_end && fw_wr_i
        |=> data_o == $past(fw_wdata_i) && !output_buffer_full_o && !data_oe_n_o
    ) else $error("firmware write during read mishandled");

    obf_set_a: assert property (
        ce_i && fw_wr_i && st_r == PBP_IDLE && !rd_start |=> output_buffer_full_o
    ) else $error("firmware write outside read did not set output full");

    read_release_a: assert property (
        read_closes_s |=> data_oe_n_o && port_event_flag_o
    ) else $error("read end did not release pins and set event");

    sync_depth_a: assert property (
        ce_i && $past(ce_i) && $past(ce_i, 2) |-> sync2_r == $past(sync1_r)
    ) else $error("synchroniser second stage did not follow the first");

    ibf_clear_a: assert property (
        pop && level == 6'h01 && !pend_r && !wr_end |=> !input_buffer_full_o
    ) else $error("last firmware read did not clear input full");

    event_hold_a: assert property (
        port_event_flag_o && !port_event_clr_i |=> port_event_flag_o
    ) else $error("port event flag dropped without a clear");
endmodule : pbp_port

// file: testbench/pbp_host_model.sv
// Behavioural external microprocessor that drives the strobes and data bus of the byte port.
`timescale 1ns/1ps
module pbp_host_model (
    input wire logic clk_i,
    input wire pbp_pkg::pbp_byte_t data_o,
    input wire logic data_oe_n_o,
    output logic rd_n_o,
    output logic wr_n_o,
    output logic cs_n_o,
    output pbp_pkg::pbp_byte_t bus_o
);
    import pbp_pkg::*;
    logic drv = 1'b0;
    pbp_byte_t hdat = 8'h00;
    pbp_byte_t last = 8'h00;
    initial begin
        rd_n_o = 1'b1;
        wr_n_o = 1'b1;
        cs_n_o = 1'b1;
    end
    // An undriven bus has no pull, so it toggles rather than keeping a stale byte.
    assign bus_o = !data_oe_n_o ? data_o : (drv ? hdat : ~last);
    always @(posedge clk_i) begin
        last <= bus_o;
    end
    // whole byte held while strobes are low, then a gap of three clocks.
    task write(input pbp_byte_t d);
        @(negedge clk_i);
        drv = 1'b1;
        hdat = d;
        cs_n_o = 1'b0;
        wr_n_o = 1'b0;
        repeat (3) @(negedge clk_i);
        cs_n_o = 1'b1;
        wr_n_o = 1'b1;
        drv = 1'b0;
        repeat (3) @(negedge clk_i);
    endtask : write
    // the byte is taken whole at a rising edge while the device still drives it.
    task read(output pbp_byte_t d, input int hold);
        int i;
        @(negedge clk_i);
        cs_n_o = 1'b0;
        rd_n_o = 1'b0;
        for (i = 0; i < 10 && data_oe_n_o !== 1'b0; i++) @(posedge clk_i);
        repeat (hold) @(posedge clk_i);
        d = bus_o;
        @(negedge clk_i);
        cs_n_o = 1'b1;
        rd_n_o = 1'b1;
        repeat (3) @(negedge clk_i);
    endtask : read
endmodule : pbp_host_model

// file: testbench/parallel_slave_byte_port_test.sv
// Self-checking testbench for the parallel slave byte port.
`timescale 1ns/1ps
module parallel_slave_byte_port_test;
    import pbp_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic ce = 1'b1;
    logic mode = 1'b1;
    logic pwm = 1'b0;
    logic fw_wr = 1'b0;
    logic fw_rd = 1'b0;
    logic ev_clr = 1'b0;
    logic [2:0] dir = 3'h7;
    logic [3:0] cfg = 4'hC;
    pbp_byte_t fw_wdata = 8'h00;
    pbp_byte_t bus, data_o, fw_rdata, d;
    logic rd_n, wr_n, cs_n, oe_n, rvalid, ev, input_buffer_full, output_buffer_full, ovf, act;
    int err_count = 0;
    int num_checks = 0;
    always #10 clk_i = ~clk_i;
    pbp_port u_pbp_port (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce),
        .slave_mode_enable_i(mode), .control_port_direction_i(dir), .analog_port_config_i(cfg),
        .pwm_multi_output_i(pwm), .control_pin_0_i(rd_n), .control_pin_1_i(wr_n),
        .control_pin_2_i(cs_n), .data_i(bus), .data_o(data_o), .data_oe_n_o(oe_n),
        .fw_wr_i(fw_wr), .fw_wdata_i(fw_wdata), .fw_rd_i(fw_rd), .fw_rdata_o(fw_rdata),
        .fw_rvalid_o(rvalid), .port_event_clr_i(ev_clr), .port_event_flag_o(ev),
        .input_buffer_full_o(input_buffer_full), .output_buffer_full_o(output_buffer_full), .overflow_o(ovf),
        .slave_active_o(act));
    pbp_host_model u_pbp_host_model (.clk_i(clk_i), .data_o(data_o), .data_oe_n_o(oe_n),
        .rd_n_o(rd_n), .wr_n_o(wr_n), .cs_n_o(cs_n), .bus_o(bus));
    task stop_test;
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : stop_test
    task chk_byte(input pbp_byte_t got, input pbp_byte_t exp, input string what);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk_byte
    task chk_bit(input logic got, input logic exp, input string what);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk_bit
    task tick(input int n);
        repeat (n) @(negedge clk_i);
    endtask : tick
    task fw_write(input pbp_byte_t v);
        @(negedge clk_i);
        fw_wr = 1'b1;
        fw_wdata = v;
        @(negedge clk_i);
        fw_wr = 1'b0;
    endtask : fw_write
    task pop(input pbp_byte_t exp);
        int i;
        for (i = 0; i < 20 && rvalid !== 1'b1; i++) @(negedge clk_i);
        chk_byte(fw_rdata, exp, "fifo head");
        fw_rd = 1'b1;
        @(negedge clk_i);
        fw_rd = 1'b0;
    endtask : pop
    task clear_event;
        @(negedge clk_i);
        ev_clr = 1'b1;
        @(negedge clk_i);
        ev_clr = 1'b0;
    endtask : clear_event
    task t_write;
        u_pbp_host_model.write(8'hA5);
        chk_bit(ev, 1'b1, "event after write");
        chk_bit(input_buffer_full, 1'b1, "ibf after write");
        pop(8'hA5);
        tick(2);
        chk_bit(input_buffer_full, 1'b0, "ibf after pop");
        clear_event();
        $display("test write done");
    endtask : t_write
    task t_read;
        fw_write(8'h3C);
        chk_bit(output_buffer_full, 1'b1, "obf after fw write");
        u_pbp_host_model.read(d, 2);
        chk_byte(d, 8'h3C, "host read");
        chk_bit(output_buffer_full, 1'b0, "obf after read");
        tick(1);
        chk_bit(oe_n, 1'b1, "pins released");
        chk_bit(ev, 1'b1, "event after read");
        clear_event();
        $display("test read done");
    endtask : t_read
    task t_read_fw;
        int i;
        fork
            u_pbp_host_model.read(d, 6);
            begin
                for (i = 0; i < 10 && oe_n !== 1'b0; i++) @(negedge clk_i);
                fw_write(8'h5A);
                chk_byte(bus, 8'h5A, "pins during read");
                chk_bit(output_buffer_full, 1'b0, "obf during read");
            end
        join
        chk_byte(d, 8'h5A, "host read new byte");
        chk_bit(output_buffer_full, 1'b0, "obf after read");
        clear_event();
        $display("test read with firmware write done");
    endtask : t_read_fw
    task t_mode;
        int i;
        // Each pass breaks exactly one of the four enabling conditions.
        for (i = 0; i < 4; i++) begin
            mode = (i != 0);
            dir = (i == 1) ? 3'h3 : 3'h7;
            cfg = (i == 2) ? 4'h9 : 4'hC;
            pwm = (i == 3);
            tick(2);
            chk_bit(act, 1'b0, "mode off");
            u_pbp_host_model.write(8'h11);
            tick(4);
            chk_bit(ev, 1'b0, "event while off");
            chk_bit(input_buffer_full, 1'b0, "ibf while off");
        end
        mode = 1'b1;
        pwm = 1'b0;
        dir = 3'h7;
        for (i = 0; i < 2; i++) begin
            cfg = i ? 4'hF : 4'hA;
            tick(2);
            chk_bit(act, 1'b1, "mode on");
            u_pbp_host_model.write({4'h2, cfg});
            pop({4'h2, cfg});
            clear_event();
        end
        $display("test mode conditions done");
    endtask : t_mode
    task t_fill;
        int i;
        // 32 FIFO words plus one pending byte; the 34th write must be lost.
        for (i = 0; i < 34; i++) u_pbp_host_model.write(i[7:0]);
        tick(6);
        chk_bit(ovf, 1'b1, "overflow");
        chk_bit(input_buffer_full, 1'b1, "ibf when full");
        for (i = 0; i < 33; i++) pop(i[7:0]);
        tick(2);
        chk_bit(input_buffer_full, 1'b0, "ibf when drained");
        chk_bit(rvalid, 1'b0, "fifo empty");
        clear_event();
        chk_bit(ovf, 1'b0, "overflow cleared");
        $display("test fill and drain done");
    endtask : t_fill
    task t_freeze;
        // A firmware write while the clock enable is low must leave every flop alone.
        ce = 1'b0;
        fw_write(8'hC3);
        tick(2);
        chk_byte(data_o, 8'h5A, "latch frozen");
        chk_bit(output_buffer_full, 1'b0, "obf frozen");
        ce = 1'b1;
        fw_write(8'hC3);
        chk_byte(data_o, 8'hC3, "latch after freeze");
        chk_bit(output_buffer_full, 1'b1, "obf after freeze");
        $display("test clock enable done");
    endtask : t_freeze
    initial begin
        #200000;
        err_count++;
        stop_test();
    end
    initial begin
        tick(4);
        rst_i = 1'b0;
        tick(2);
        chk_bit(oe_n, 1'b1, "oe after reset");
        chk_bit(ev, 1'b0, "event after reset");
        chk_bit(output_buffer_full, 1'b0, "obf after reset");
        chk_byte(data_o, 8'h00, "latch after reset");
        t_write();
        t_read();
        t_read_fw();
        t_mode();
        t_fill();
        t_freeze();
        stop_test();
    end
endmodule : parallel_slave_byte_port_test
